// >>> src/sfm_pkg.sv
package sfm_pkg;
	// Register byte offsets
	localparam logic [5:0] OFF_CTRL = 6'h00;
	localparam logic [5:0] OFF_SYNTH = 6'h04;
	localparam logic [5:0] OFF_SPACING = 6'h08;
	localparam logic [5:0] OFF_CHANNEL = 6'h0c;
	localparam logic [5:0] OFF_MOD = 6'h10;
	localparam logic [5:0] OFF_TAP_DIV = 6'h14;
	localparam logic [5:0] OFF_CAL_TX = 6'h18;
	localparam logic [5:0] OFF_CAL_RX = 6'h1c;
	localparam logic [5:0] OFF_STATUS = 6'h20;
	localparam logic [5:0] OFF_FREQ = 6'h24;
	localparam logic [5:0] OFF_DEV = 6'h28;
	// Reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [27:0] SYNTH_RST = 28'h000_0000;
	localparam logic [15:0] TAP_DIV_RST = 16'h0010;
	localparam logic [7:0] CAL_RST = 8'h00;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Modulation select codes
	localparam logic [3:0] MOD_2FSK = 4'h0;
	localparam logic [3:0] MOD_4FSK = 4'h1;
	localparam logic [3:0] MOD_2GFSK = 4'h2;
	localparam logic [3:0] MOD_4GFSK = 4'h3;
	localparam logic [3:0] MOD_ASK = 4'h5;
	localparam logic [3:0] MOD_POLAR = 4'h6;
	localparam logic [3:0] MOD_CW = 4'h7;
	// Radio state codes from the main controller
	localparam logic [1:0] RADIO_READY = 2'h0;
	localparam logic [1:0] RADIO_LOCK = 2'h1;
	localparam logic [1:0] RADIO_TX = 2'h2;
	localparam logic [1:0] RADIO_RX = 2'h3;
	// Shaping and interpolation figures
	localparam logic [2:0] TAPS_LAST = 3'h7;
	localparam logic [3:0] INTERP_EXP_LO = 4'h5;
	localparam logic [3:0] INTERP_EXP_OFF = 4'hb;
	localparam logic [3:0] INTERP_LG_MAX = 4'h6;
	localparam logic [4:0] COEF_FULL = 5'h10;
	// Control register layout, bit 0 first from the bottom
	typedef struct packed {
		logic [11:0] unused;
		logic tx_enable;
		logic phase_detector_split_enable;
		logic [2:0] charge_pump_current_sel;
		logic [1:0] equalizer_control;
		logic gaussian_interp_enable;
		logic gaussian_bt_select;
		logic quad_symbol_bit_swap;
		logic [1:0] const_map;
		logic [3:0] modulation_select;
		logic cal_disable;
		logic xo_double_rate;
		logic band_select;
		logic reference_halving;
	} sfm_ctrl_t;
	// Deviation and rate exponent layout
	typedef struct packed {
		logic [15:0] unused;
		logic [3:0] rate_exp;
		logic [3:0] dev_exp;
		logic [7:0] dev_mant;
	} sfm_mod_t;
	// Calibration sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CAL_WAIT
	} sfm_cal_state_t;
endpackage : sfm_pkg

// >>> src/sfm_shaper.sv
`timescale 1ns/1ps
`default_nettype none
module sfm_shaper
	import sfm_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Symbol timing and level
	input wire logic tap_en,
	input wire logic [2:0] tap_phase,
	input wire logic signed [31:0] level,
	input wire logic [15:0] tap_div,
	// Shaping controls
	input wire logic shape_en,
	input wire logic bt_half,
	input wire logic interp_en,
	input wire logic [3:0] rate_exp,
	// Shaped deviation
	output logic signed [31:0] shaped
);
	logic signed [31:0] prev_reg;
	logic signed [31:0] target;
	logic signed [31:0] delta_reg;
	logic [5:0] step_cnt_reg;
	logic [15:0] sub_cnt_reg;
	logic [3:0] lg;
	logic [15:0] sub_div;
	logic [4:0] coef;

	// BT selects coefficient set; eight phases per symbol
	always_comb begin
		unique case ({bt_half, tap_phase})
			4'h0: coef = 5'h03;
			4'h1: coef = 5'h07;
			4'h2: coef = 5'h0b;
			4'h3: coef = 5'h0e;
			4'h8: coef = 5'h02;
			4'h9: coef = 5'h04;
			4'ha: coef = 5'h06;
			4'hb: coef = 5'h08;
			4'hc: coef = 5'h0a;
			4'hd: coef = 5'h0c;
			4'he: coef = 5'h0e;
			default: coef = COEF_FULL;
		endcase
	end

	// Two-symbol poly-phase blend; plain FSK steps straight to the level
	assign target = shape_en ? prev_reg + ((level - prev_reg) * $signed({1'b0, coef})) / 16 : level;

	// interpolation factor as a shift: 64, then halving, off at 11
	always_comb begin
		if (!interp_en || !shape_en || rate_exp >= INTERP_EXP_OFF)
			lg = 4'h0;
		else if (rate_exp < INTERP_EXP_LO)
			lg = INTERP_LG_MAX;
		else
			lg = INTERP_EXP_OFF - rate_exp;
	end
	assign sub_div = (tap_div >> lg) == 16'h0000 ? 16'h0001 : tap_div >> lg;

	// Previous symbol level, taken at the start of each symbol
	always_ff @(posedge aclk) begin
		if (!aresetn)
			prev_reg <= 32'sh0;
		else if (tap_en && tap_phase == TAPS_LAST)
			prev_reg <= level;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shaped <= 32'sh0;
			delta_reg <= 32'sh0;
			step_cnt_reg <= 6'h00;
			sub_cnt_reg <= 16'h0000;
		end else if (tap_en) begin
			sub_cnt_reg <= 16'h0000;
			if (lg == 4'h0) begin
				shaped <= target;
				step_cnt_reg <= 6'h00;
			end else begin
				delta_reg <= (target - shaped) >>> lg;
				step_cnt_reg <= 6'((7'h01 << lg) - 7'h01);
			end
		end else if (step_cnt_reg != 6'h00) begin
			if (sub_cnt_reg + 16'h0001 >= sub_div) begin
				sub_cnt_reg <= 16'h0000;
				shaped <= shaped + delta_reg;
				step_cnt_reg <= step_cnt_reg - 6'h01;
			end else begin
				sub_cnt_reg <= sub_cnt_reg + 16'h0001;
			end
		end
	end
endmodule : sfm_shaper
`default_nettype wire

// >>> src/sfm_synth_mod.sv
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module sfm_synth_mod
	import sfm_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [5:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [5:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Radio state and analog calibration
	input wire logic [1:0] radio_mode,
	input wire logic cal_done,
	input wire logic [7:0] cal_result,
	output logic cal_start,
	// Synthesizer controls
	output logic [31:0] synth_freq_word,
	output logic [7:0] synth_cal_word,
	output logic synth_apply,
	output logic [2:0] charge_pump_current_sel,
	output logic phase_detector_split_enable,
	output logic xo_clock_halve,
	output logic [1:0] equalizer_control,
	// Payload bytes from the packet handler
	input wire logic [7:0] pay_data,
	input wire logic pay_valid,
	output logic pay_ready
);
	sfm_ctrl_t ctrl_reg;
	sfm_mod_t mod_reg;
	logic [27:0] synth_word_reg;
	logic [7:0] spacing_reg;
	logic [7:0] channel_reg;
	logic [15:0] tap_div_reg;
	logic [7:0] cal_tx_reg;
	logic [7:0] cal_rx_reg;
	logic [5:0] aw_addr_reg;
	logic aw_held_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic w_held_reg;
	logic do_write;
	logic [1:0] prev_mode_reg;
	sfm_cal_state_t cal_state_reg;
	logic cal_for_tx_reg;
	logic synth_locked_reg;
	logic [31:0] fc_reg;
	logic [31:0] fc_calc;
	logic [31:0] dev_outer;
	logic [31:0] dev_inner;
	logic lock_trigger;
	logic [15:0] tap_cnt_reg;
	logic [2:0] phase_reg;
	logic tap_en;
	logic sym_edge;
	logic [7:0] shift_reg;
	logic [2:0] sym_left_reg;
	logic signed [31:0] level_reg;
	logic signed [31:0] shaped;
	logic fsk_mode;
	logic quad_mode;
	logic gauss_mode;
	logic mod_run;
	logic [1:0] next_sym;

	// Byte-lane merge for register writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i])
				res[8*i +: 8] = data[8*i +: 8];
		end
		return res;
	endfunction : merge

	// Address decode shared by reads and writes
	function automatic logic mapped(input logic [5:0] a);
		return a[1:0] == 2'h0 && a <= OFF_DEV;
	endfunction : mapped

	// level of a symbol; two-level uses the outer magnitude
	function automatic logic signed [31:0] sym_level(input logic quad, input logic [1:0] sym,
		input logic [1:0] code, input logic [31:0] outer, input logic [31:0] inner);
		logic [31:0] mag;
		logic neg;
		mag = (!quad || (sym[0] ^ code[0])) ? outer : inner;
		neg = quad ? (sym[1] == code[1]) : (sym[0] == code[1]);
		return neg ? -$signed(mag) : $signed(mag);
	endfunction : sym_level

	// scheme decode; ASK and direct polar carry no frequency symbols here
	always_comb begin
		unique case (ctrl_reg.modulation_select)
			MOD_2FSK, MOD_4FSK, MOD_2GFSK, MOD_4GFSK: fsk_mode = 1'b1;
			MOD_ASK, MOD_POLAR, MOD_CW: fsk_mode = 1'b0;
			default: fsk_mode = 1'b0;
		endcase
	end
	assign quad_mode = ctrl_reg.modulation_select[0];
	assign gauss_mode = ctrl_reg.modulation_select[1];

	// AXI address and data may arrive in either order
	assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
	assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	// Holding registers for the write channels
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			aw_addr_reg <= 6'h00;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end else if (do_write) begin
				aw_held_reg <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end else if (do_write) begin
				w_held_reg <= 1'b0;
			end
		end
	end

	// Write response, error for unmapped or read-only words
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (mapped(aw_addr_reg) && aw_addr_reg < OFF_STATUS) ? RESP_OKAY
				: RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Configuration registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= CTRL_RST;
			mod_reg <= '0;
			synth_word_reg <= SYNTH_RST;
			spacing_reg <= 8'h00;
			channel_reg <= 8'h00;
			tap_div_reg <= TAP_DIV_RST;
		end else if (do_write) begin
			unique case (aw_addr_reg)
				OFF_CTRL: ctrl_reg <= merge(ctrl_reg, w_data_reg, w_strb_reg) & 32'h000f_ffff;
				OFF_SYNTH: synth_word_reg <= 28'(merge({4'h0, synth_word_reg}, w_data_reg,
					w_strb_reg));
				OFF_SPACING: spacing_reg <= 8'(merge({24'h0, spacing_reg}, w_data_reg,
					w_strb_reg));
				// channel index alone in its own word
				OFF_CHANNEL: channel_reg <= 8'(merge({24'h0, channel_reg}, w_data_reg,
					w_strb_reg));
				OFF_MOD: mod_reg <= merge(mod_reg, w_data_reg, w_strb_reg) & 32'h0000_ffff;
				OFF_TAP_DIV: tap_div_reg <= 16'(merge({16'h0, tap_div_reg}, w_data_reg,
					w_strb_reg));
				default: ;
			endcase
		end
	end

	// calibration results win over a software write in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cal_tx_reg <= CAL_RST;
			cal_rx_reg <= CAL_RST;
		end else if (cal_state_reg == ST_CAL_WAIT && cal_done) begin
			if (cal_for_tx_reg)
				cal_tx_reg <= cal_result;
			else
				cal_rx_reg <= cal_result;
		end else if (do_write && aw_addr_reg == OFF_CAL_TX) begin
			cal_tx_reg <= 8'(merge({24'h0, cal_tx_reg}, w_data_reg, w_strb_reg));
		end else if (do_write && aw_addr_reg == OFF_CAL_RX) begin
			cal_rx_reg <= 8'(merge({24'h0, cal_rx_reg}, w_data_reg, w_strb_reg));
		end
	end

	// Read data, registered one cycle after the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			unique case (s_axi_araddr)
				OFF_CTRL: s_axi_rdata <= ctrl_reg;
				OFF_SYNTH: s_axi_rdata <= {4'h0, synth_word_reg};
				OFF_SPACING: s_axi_rdata <= {24'h0, spacing_reg};
				OFF_CHANNEL: s_axi_rdata <= {24'h0, channel_reg};
				OFF_MOD: s_axi_rdata <= mod_reg;
				OFF_TAP_DIV: s_axi_rdata <= {16'h0, tap_div_reg};
				OFF_CAL_TX: s_axi_rdata <= {24'h0, cal_tx_reg};
				OFF_CAL_RX: s_axi_rdata <= {24'h0, cal_rx_reg};
				OFF_STATUS: s_axi_rdata <= {24'h0, synth_cal_word[3:0], 1'b0, fsk_mode,
					cal_state_reg == ST_CAL_WAIT, synth_locked_reg};
				OFF_FREQ: s_axi_rdata <= fc_reg;
				OFF_DEV: s_axi_rdata <= dev_outer;
				default: s_axi_rdata <= 32'h0000_0000;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Centre frequency in units of the reference over 2^23.
	// base is word*16/(B*D): shift left by 2 less band and halving bits
	// spacing step of reference/2^15 is 2^8 units, times index
	assign fc_calc = 32'({4'h0, synth_word_reg} << (2'h2 - {1'b0, ctrl_reg.band_select}
		- {1'b0, ctrl_reg.reference_halving}))
		+ {8'h00, {8'h00, spacing_reg} * {8'h00, channel_reg}, 8'h00}; // 16-bit product

	// deviation in the same units: 16*round(D*M*B/8)/(D*B)
	always_comb begin
		logic [31:0] m;
		logic [31:0] n;
		m = 32'h0000_0000;
		n = 32'h0000_0000;
		if (mod_reg.dev_exp == 4'h0)
			m = {24'h0, mod_reg.dev_mant};
		else
			m = ({23'h0, 1'b1, mod_reg.dev_mant} << (mod_reg.dev_exp - 4'h1));
		n = m << (3'h2 + {2'b0, ctrl_reg.band_select} + {2'b0, ctrl_reg.reference_halving});
		n = (n + 32'h0000_0004) >> 3;
		dev_outer = n << (2'h2 - {1'b0, ctrl_reg.band_select}
			- {1'b0, ctrl_reg.reference_halving});
	end
	assign dev_inner = dev_outer / 32'h0000_0003;

	// lock from ready, and every receive-transmit swap
	assign lock_trigger = (prev_mode_reg == RADIO_READY && radio_mode != RADIO_READY)
		|| (prev_mode_reg == RADIO_TX && radio_mode == RADIO_RX)
		|| (prev_mode_reg == RADIO_RX && radio_mode == RADIO_TX);

	// Calibration and lock sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev_mode_reg <= RADIO_READY;
			cal_state_reg <= ST_IDLE;
			cal_for_tx_reg <= 1'b0;
			cal_start <= 1'b0;
			synth_apply <= 1'b0;
			synth_locked_reg <= 1'b0;
			synth_cal_word <= CAL_RST;
			fc_reg <= 32'h0000_0000;
		end else begin
			prev_mode_reg <= radio_mode;
			cal_start <= 1'b0;
			synth_apply <= 1'b0;
			if (radio_mode == RADIO_READY) begin
				cal_state_reg <= ST_IDLE;
				synth_locked_reg <= 1'b0;
			end else if (lock_trigger) begin
				fc_reg <= fc_calc;
				cal_for_tx_reg <= radio_mode != RADIO_RX;
				synth_locked_reg <= 1'b0;
				if (ctrl_reg.cal_disable) begin
					synth_cal_word <= radio_mode == RADIO_RX ? cal_rx_reg : cal_tx_reg;
					synth_apply <= 1'b1;
					synth_locked_reg <= 1'b1;
					cal_state_reg <= ST_IDLE;
				end else begin
					cal_start <= 1'b1;
					cal_state_reg <= ST_CAL_WAIT;
				end
			end else if (cal_state_reg == ST_CAL_WAIT && cal_done) begin
				// result used at once and kept in its register
				synth_cal_word <= cal_result;
				synth_apply <= 1'b1;
				synth_locked_reg <= 1'b1;
				cal_state_reg <= ST_IDLE;
			end
		end
	end

	// Modulator runs only while locked for transmit in a frequency scheme
	assign mod_run = ctrl_reg.tx_enable && synth_locked_reg && radio_mode == RADIO_TX && fsk_mode;

	// Tap divider: one enable per filter phase, eight per symbol
	assign tap_en = mod_run && tap_cnt_reg + 16'h0001 >= tap_div_reg;
	assign sym_edge = tap_en && phase_reg == TAPS_LAST;
	always_ff @(posedge aclk) begin
		if (!aresetn || !mod_run) begin
			tap_cnt_reg <= 16'h0000;
			phase_reg <= 3'h0;
		end else if (tap_en) begin
			tap_cnt_reg <= 16'h0000;
			phase_reg <= phase_reg + 3'h1;
		end else begin
			tap_cnt_reg <= tap_cnt_reg + 16'h0001;
		end
	end

	// Next symbol from the top of the byte; swap reverses each pair
	assign next_sym = !quad_mode ? {1'b0, shift_reg[7]}
		: ctrl_reg.quad_symbol_bit_swap ? {shift_reg[6], shift_reg[7]} : shift_reg[7:6];
	// New byte taken only at a symbol edge once the last is spent
	assign pay_ready = sym_edge && sym_left_reg == 3'h0;

	// byte splits into S0..S3 (or eight bits), one per symbol period
	always_ff @(posedge aclk) begin
		if (!aresetn || !mod_run) begin
			shift_reg <= 8'h00;
			sym_left_reg <= 3'h0;
			level_reg <= 32'sh0;
		end else if (sym_edge) begin
			if (sym_left_reg != 3'h0) begin
				level_reg <= sym_level(quad_mode, next_sym, ctrl_reg.const_map,
					dev_outer, dev_inner);
				shift_reg <= quad_mode ? {shift_reg[5:0], 2'b00} : {shift_reg[6:0], 1'b0};
				sym_left_reg <= sym_left_reg - 3'h1;
			end else if (pay_valid) begin
				// First symbol leaves now, so only the rest stays in the shifter
				shift_reg <= quad_mode ? {pay_data[5:0], 2'b00} : {pay_data[6:0], 1'b0};
				sym_left_reg <= quad_mode ? 3'h3 : 3'h7;
				level_reg <= sym_level(quad_mode, quad_mode ? (ctrl_reg.quad_symbol_bit_swap
					? {pay_data[6], pay_data[7]} : pay_data[7:6]) : {1'b0, pay_data[7]},
					ctrl_reg.const_map, dev_outer, dev_inner);
			end else begin
				// Underrun leaves the carrier at centre
				level_reg <= 32'sh0;
			end
		end
	end

	sfm_shaper u_shaper (
		.aclk(aclk),
		.aresetn(aresetn),
		.tap_en(tap_en),
		.tap_phase(phase_reg),
		.level(level_reg),
		.tap_div(tap_div_reg),
		.shape_en(gauss_mode),
		.bt_half(ctrl_reg.gaussian_bt_select),
		.interp_en(ctrl_reg.gaussian_interp_enable),
		.rate_exp(mod_reg.rate_exp),
		.shaped(shaped)
	);

	// Frequency word out: captured centre plus modulation offset
	always_ff @(posedge aclk) begin
		if (!aresetn)
			synth_freq_word <= 32'h0000_0000;
		else
			synth_freq_word <= fc_reg + (mod_run ? shaped : 32'sh0);
	end

	// static controls passed to the analog side
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			xo_clock_halve <= 1'b0;
			charge_pump_current_sel <= 3'h0;
			phase_detector_split_enable <= 1'b0;
			equalizer_control <= 2'h0;
		end else begin
			xo_clock_halve <= ctrl_reg.xo_double_rate;
			charge_pump_current_sel <= ctrl_reg.charge_pump_current_sel;
			phase_detector_split_enable <= ctrl_reg.phase_detector_split_enable;
			equalizer_control <= ctrl_reg.equalizer_control;
		end
	end
endmodule : sfm_synth_mod
`default_nettype wire

// >>> verif/sfm_synth_mod_properties.sv
`timescale 1ns/1ps
`default_nettype none
module sfm_synth_mod_properties
	import sfm_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bus handshakes
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Radio, synthesizer and payload
	input wire logic [1:0] radio_mode,
	input wire logic cal_start,
	input wire logic synth_apply,
	input wire logic pay_ready
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Bus refusals and answers
	aw_refused_a: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write address open during response");
	b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	ar_refused_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address open during data");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data repeated");
	// Lock triggers answered next cycle
	lock_start_a: assert property (
		$past(radio_mode) == RADIO_READY && radio_mode != RADIO_READY
		|=> cal_start || synth_apply) else $error("lock not started");
	dir_switch_a: assert property (
		$past(radio_mode) == RADIO_TX && radio_mode == RADIO_RX
		|| $past(radio_mode) == RADIO_RX && radio_mode == RADIO_TX
		|=> cal_start || synth_apply) else $error("switch not recalibrated");
	// Pulses and symbol pacing
	cal_pulse_a: assert property (cal_start |=> !cal_start)
		else $error("calibration start too long");
	apply_pulse_a: assert property (synth_apply |=> !synth_apply)
		else $error("apply too long");
	pay_gap_a: assert property (pay_ready |=> !pay_ready [*7])
		else $error("symbols shorter than eight taps");
endmodule : sfm_synth_mod_properties
bind sfm_synth_mod sfm_synth_mod_properties u_props (
	.aclk(aclk),
	.aresetn(aresetn),
	.s_axi_awready(s_axi_awready),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.radio_mode(radio_mode),
	.cal_start(cal_start),
	.synth_apply(synth_apply),
	.pay_ready(pay_ready)
);
`default_nettype wire

// >>> verif/sfm_pay_src.sv
`timescale 1ns/1ps
`default_nettype none
module sfm_pay_src (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Byte to offer
	input wire logic src_en,
	input wire logic [7:0] src_byte,
	// Payload handshake
	input wire logic pay_ready,
	output logic [7:0] pay_data,
	output logic pay_valid
);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pay_valid <= 1'b0;
			pay_data <= 8'h00;
		end else if (!pay_valid || pay_ready) begin
			pay_valid <= src_en;
			// Released lane toggles between the last byte and its complement
			pay_data <= src_en ? src_byte : ~pay_data;
		end
	end
endmodule : sfm_pay_src
`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import sfm_pkg::*;
	// Stimulus, outputs and counters
	localparam logic [7:0] PB = 8'h1b;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [5:0] awaddr = 6'h00;
	logic [5:0] araddr = 6'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic arvalid = 1'b0;
	logic [1:0] radio_mode = 2'h0;
	logic cal_done = 1'b0;
	logic [7:0] cal_result = 8'h00;
	logic src_en = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, cal_start, synth_apply;
	logic pay_ready, pay_valid, xo, split;
	logic [1:0] bresp, rresp, eq, r;
	logic [2:0] cp;
	logic [7:0] cal_word, pay_data;
	logic [31:0] rdata, sfw;
	logic [31:0] f = 32'h44fb00;
	int n_mismatch = 0;
	int checks_done = 0;
	always #25 aclk = ~aclk;
	sfm_synth_mod dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(1'b1), .radio_mode(radio_mode), .cal_done(cal_done),
		.cal_result(cal_result), .cal_start(cal_start), .synth_freq_word(sfw),
		.synth_cal_word(cal_word), .synth_apply(synth_apply),
		.charge_pump_current_sel(cp), .phase_detector_split_enable(split),
		.xo_clock_halve(xo), .equalizer_control(eq), .pay_data(pay_data),
		.pay_valid(pay_valid), .pay_ready(pay_ready));
	sfm_pay_src u_src (.aclk(aclk), .aresetn(aresetn), .src_en(src_en),
		.src_byte(PB), .pay_ready(pay_ready), .pay_data(pay_data),
		.pay_valid(pay_valid));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: saw %h expected %h", $time, s, e);
		end
	endtask : chk
	// Write: both channels offered, each released when taken
	task automatic wr(input logic [5:0] a, input logic [31:0] v);
		logic ta, tw, da, dw;
		da = 1'b0;
		dw = 1'b0;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(da && dw)) begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			da = da | ta;
			dw = dw | tw;
		end
		do begin
			@(negedge aclk);
			ta = bvalid;
			r = bresp;
			@(posedge aclk);
		end while (!ta);
	endtask : wr
	// Read and compare
	task automatic rc(input logic [5:0] a, input logic [31:0] e);
		logic t;
		logic [31:0] v;
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(negedge aclk);
			t = arready;
			@(posedge aclk);
		end while (!t);
		arvalid <= 1'b0;
		do begin
			@(negedge aclk);
			t = rvalid;
			v = rdata;
			r = rresp;
			@(posedge aclk);
		end while (!t);
		chk(v, e);
	endtask : rc
	task automatic mode(input logic [1:0] m);
		radio_mode <= m;
		repeat (4) @(posedge aclk);
	endtask : mode
	task automatic cal(input logic [1:0] m, input logic [7:0] v);
		int k;
		radio_mode <= m;
		k = 0;
		do begin
			@(negedge aclk);
			k++;
		end while (cal_start !== 1'b1 && k < 8);
		chk({31'h0, cal_start}, 32'h1);
		@(posedge aclk);
		cal_done <= 1'b1;
		cal_result <= v;
		@(posedge aclk);
		cal_done <= 1'b0;
		@(posedge aclk);
		@(negedge aclk);
		chk({24'h0, cal_word}, {24'h0, v});
		@(posedge aclk);
	endtask : cal
	// Sample the first symbol d cycles after a byte is taken, then every eight cycles
	task automatic syms(input int n, input logic [1:0] c, input logic sw, input int d);
		logic [1:0] p;
		logic [31:0] e;
		do @(negedge aclk); while (!(pay_valid && pay_ready));
		@(posedge aclk);
		for (int k = 0; k < n; k++) begin
			repeat (k == 0 ? d : 8) @(posedge aclk);
			@(negedge aclk);
			if (n == 4) begin
				p = sw ? {PB[6-2*k], PB[7-2*k]} : {PB[7-2*k], PB[6-2*k]};
				e = (p[0] ^ c[0]) ? 32'd128 : 32'd42;
				if (p[1] == c[1]) e = -e;
			end else begin
				e = 32'd128;
				if (PB[7-k] == c[1]) e = -e;
			end
			chk(sfw, f + e);
		end
		@(posedge aclk);
	endtask : syms
	task automatic t_regs;
		rc(OFF_CTRL, 32'h0);
		rc(OFF_TAP_DIV, 32'h10);
		rc(6'h2c, 32'h0);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		wr(OFF_STATUS, 32'h1);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		wr(OFF_CTRL, 32'h5c004);
		repeat (2) @(negedge aclk);
		chk({25'h0, xo, split, cp, eq}, {25'h0, 7'h6e});
		@(posedge aclk);
		rc(OFF_CTRL, 32'h5c004);
		$display("register test done");
	endtask : t_regs
	task automatic t_freq;
		wr(OFF_SYNTH, 32'h100000);
		wr(OFF_SPACING, 32'h5);
		wr(OFF_CHANNEL, 32'h3);
		wr(OFF_CAL_TX, 32'h5a);
		wr(OFF_CTRL, 32'hb);
		mode(RADIO_LOCK);
		rc(OFF_FREQ, 32'h100f00);
		@(negedge aclk);
		chk({24'h0, cal_word}, 32'h5a);
		@(posedge aclk);
		wr(OFF_CHANNEL, 32'hff);
		wr(OFF_CTRL, 32'h8);
		rc(OFF_FREQ, 32'h100f00);
		mode(RADIO_READY);
		mode(RADIO_LOCK);
		rc(OFF_FREQ, f);
		mode(RADIO_READY);
		$display("frequency test done");
	endtask : t_freq
	task automatic t_cal;
		wr(OFF_CTRL, 32'h0);
		cal(RADIO_TX, 8'h3c);
		rc(OFF_CAL_TX, 32'h3c);
		cal(RADIO_RX, 8'h77);
		rc(OFF_CAL_RX, 32'h77);
		mode(RADIO_READY);
		$display("calibration test done");
	endtask : t_cal
	task automatic t_dev;
		wr(OFF_CTRL, 32'h8);
		wr(OFF_MOD, 32'h3);
		rc(OFF_DEV, 32'h8);
		wr(OFF_MOD, 32'h200);
		rc(OFF_DEV, 32'h400);
		wr(OFF_MOD, 32'h40);
		rc(OFF_DEV, 32'h80);
		$display("deviation test done");
	endtask : t_dev
	task automatic t_pay;
		wr(OFF_TAP_DIV, 32'h1);
		mode(RADIO_TX);
		src_en <= 1'b1;
		for (int c = 0; c < 4; c++) begin
			wr(OFF_CTRL, 32'h80018 | (c << 8));
			syms(4, c[1:0], 1'b0, 4);
		end
		wr(OFF_CTRL, 32'h80418);
		syms(4, 2'h0, 1'b1, 4);
		wr(OFF_CTRL, 32'h80008);
		syms(8, 2'h0, 1'b0, 4);
		wr(OFF_CTRL, 32'h80208);
		syms(8, 2'h2, 1'b0, 4);
		// Shaped symbols settle on their level late in the symbol
		wr(OFF_CTRL, 32'h80028);
		syms(8, 2'h0, 1'b0, 7);
		wr(OFF_CTRL, 32'h80828);
		syms(8, 2'h0, 1'b0, 9);
		wr(OFF_CTRL, 32'h80078);
		repeat (20) @(negedge aclk);
		chk(sfw, f);
		@(posedge aclk);
		src_en <= 1'b0;
		$display("payload test done");
	endtask : t_pay
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : report_and_stop
	// Main sequence after reset
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs;
		t_freq;
		t_cal;
		t_dev;
		t_pay;
		report_and_stop;
	end
	// Watchdog well beyond the expected run
	initial begin
		#2000000;
		n_mismatch++;
		report_and_stop;
	end
endmodule : testbench
`default_nettype wire
